/* logic/pin_select_pkg.sv */
// pin function selection package: register offsets, reset values, pin functions
// assumes a 32-bit apb register bus, one word per register
package pin_select_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] DIR_OFF = 8'h00;     // port2_direction, whole byte
  localparam logic [7:0] DIR_BIT_OFF = 8'h04; // single-bit write of direction
  localparam logic [7:0] SEG_OFF = 8'h08;     // segment_or_port_select
  localparam logic [7:0] ADPC_OFF = 8'h0c;    // analog_digital_pin_select
  localparam logic [7:0] SAR_OFF = 8'h10;     // sar_channel_select
  localparam logic [7:0] DS_OFF = 8'h14;      // deltasigma_channel_control
  localparam logic [7:0] FUNC_LO_OFF = 8'h18; // pin function, pins 0..3
  localparam logic [7:0] FUNC_HI_OFF = 8'h1c; // pin function, pins 4..7
  // ==========================================================
  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam logic [7:0] ADPC_RESET = 8'h00;
  localparam logic [3:0] SAR_RESET = 4'h0;
  localparam logic [3:0] DS_RESET = 4'h0;
  // bit-write layout: bit 3 = value, bits 2:0 = bit index
  localparam int BITW_VAL_POS = 3;
  // ==========================================================
  // per-pin function, 4-bit code fits into 4 bits of a status word
  typedef enum logic [3:0] {
    FN_DIG_IN, FN_DIG_OUT, FN_ANALOG_IDLE, FN_ANALOG_SAR, FN_ANALOG_DS,
    FN_SEGMENT, FN_PROHIBITED
  } pin_fn_t;
endpackage

/* logic/pin_select_if.sv */
// settings carried from the register file to the pin decoder and its results
// assumes one clock; all signals are levels
`timescale 1ns/100ps
interface pin_select_if;
  logic [7:0] dir;     // 1 = input
  logic [7:0] segment_output;     // 1 = segment output
  logic [7:0] analog;  // 1 = analog pin
  logic [3:0] sar_sel; // bit 3 enable, 2:0 channel
  logic [3:0] ds_sel;  // bit 3 enable, 2:0 channel
  logic ds_variant;    // delta-sigma device variant
  logic [31:0] fn_flat; // pin_fn_t per pin, 4 bits each
  modport regs(output dir, segment_output, analog, sar_sel, ds_sel, ds_variant, input fn_flat);
  modport dec(input dir, segment_output, analog, sar_sel, ds_sel, ds_variant, output fn_flat);
endinterface

/* logic/pin_fn_decode.sv */
// combinational decode of each pin's function from the five settings
// assumes settings are stable register outputs
`timescale 1ns/100ps
module pin_fn_decode
  import pin_select_pkg::*;
(
  pin_select_if.dec sel // settings in, functions out
);
  // ==========================================================
  // decode per pin
  function automatic pin_fn_t decode_pin(input logic [2:0] n, input logic dir,
                                         input logic segment_output, input logic ana);
    logic sar_hit;
    logic ds_hit;
    sar_hit = sel.sar_sel[3] && (sel.sar_sel[2:0] == n);
    ds_hit = sel.ds_variant && sel.ds_sel[3] && (sel.ds_sel[2:0] == n);
    // segment wins over everything else on the segment variant
    if (segment_output && !sel.ds_variant) decode_pin = FN_SEGMENT;
    else if (!ana) decode_pin = dir ? FN_DIG_IN : FN_DIG_OUT;
    else if (!dir) decode_pin = FN_PROHIBITED; // analog with output
    else if (sar_hit && ds_hit) decode_pin = FN_PROHIBITED;
    else if (sar_hit) decode_pin = FN_ANALOG_SAR;
    else if (ds_hit) decode_pin = FN_ANALOG_DS;
    else decode_pin = FN_ANALOG_IDLE;
  endfunction

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sel.fn_flat[i*4 +: 4] = decode_pin(3'(i), sel.dir[i], sel.segment_output[i], sel.analog[i]);
    end
  end
endmodule

/* logic/port2_analog_pin_select.sv */
// port 2 pin function select: apb registers plus registered pin routing
// assumes a synchronous apb master on clk; converters sample the routing outputs
//
// What this block does
// - direction bit 0 drives the pin as output, 1 makes it an input
// - reset loads the direction register with all ones
// - a pin in output direction is never offered to the converters
// - direction register takes whole-byte writes and single-bit writes
// - analog input not selected by any converter stays unconverted
// - analog input picked by the sar select goes to the sar converter
// - delta-sigma pick routes to delta-sigma; picking both is prohibited
// - segment choice overrides; analog plus output direction is prohibited
`timescale 1ns/100ps
module port2_analog_pin_select
  import pin_select_pkg::*;
#(
  parameter bit DS_VARIANT = 1'b0 // 1 = delta-sigma device variant
) (
  input wire logic clk,             // 200 MHz clock
  input wire logic arst_n,          // async reset, active low
  input wire logic psel,            // apb select
  input wire logic penable,         // apb enable
  input wire logic pwrite,          // apb direction
  input wire logic [7:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,   // apb write data
  output logic [31:0] prdata,       // apb read data
  output logic pready,              // apb ready
  output logic pslverr,             // apb error, unmapped address
  output logic [7:0] out_enable_n,  // pin output buffer enable, low = drive
  output logic [7:0] seg_enable,    // pin given to segment driver
  output logic [7:0] sar_route,     // pin routed to sar converter
  output logic [7:0] ds_route,      // pin routed to delta-sigma converter
  output logic [7:0] analog_mode,   // pin in analog mode (digital input off)
  output logic prohibited           // a prohibited setting is present
);
  // ==========================================================
  // reset synchroniser
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // setting registers
  logic [7:0] dir_reg, dir_next;
  logic [7:0] seg_reg, seg_next;
  logic [7:0] adpc_reg, adpc_next;
  logic [3:0] sar_reg, sar_next;
  logic [3:0] ds_reg, ds_next;
  pin_select_if sel_if();

  // apb decode; a one-cycle access phase, pready in the access cycle
  wire access = psel && penable;
  // a write lands only at the edge that also sees pready, never in a stretched access
  wire wr = access && pwrite && pready;
  wire hit_dir = (paddr == DIR_OFF);
  wire hit_bit = (paddr == DIR_BIT_OFF);
  wire hit_seg = (paddr == SEG_OFF);
  wire hit_adpc = (paddr == ADPC_OFF);
  wire hit_sar = (paddr == SAR_OFF);
  wire hit_ds = (paddr == DS_OFF);
  wire hit_flo = (paddr == FUNC_LO_OFF);
  wire hit_fhi = (paddr == FUNC_HI_OFF);
  wire mapped = hit_dir | hit_bit | hit_seg | hit_adpc | hit_sar | hit_ds | hit_flo | hit_fhi;
  wire [2:0] bit_idx = pwdata[2:0];
  wire bit_val = pwdata[BITW_VAL_POS];

  // next values: whole byte or one bit of the direction register
  always_comb begin
    dir_next = dir_reg;
    if (wr && hit_dir) dir_next = pwdata[7:0];
    else if (wr && hit_bit) dir_next[bit_idx] = bit_val;
  end
  assign seg_next = (wr && hit_seg) ? pwdata[7:0] : seg_reg;
  assign adpc_next = (wr && hit_adpc) ? pwdata[7:0] : adpc_reg;
  assign sar_next = (wr && hit_sar) ? pwdata[3:0] : sar_reg;
  assign ds_next = (wr && hit_ds) ? pwdata[3:0] : ds_reg;

  // direction resets to all inputs so no pin drives at power-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_reg <= DIR_RESET;
      seg_reg <= SEG_RESET;
      adpc_reg <= ADPC_RESET;
      sar_reg <= SAR_RESET;
      ds_reg <= DS_RESET;
    end else if (!rst_n_reg) begin
      dir_reg <= DIR_RESET;
      seg_reg <= SEG_RESET;
      adpc_reg <= ADPC_RESET;
      sar_reg <= SAR_RESET;
      ds_reg <= DS_RESET;
    end else begin
      dir_reg <= dir_next;
      seg_reg <= seg_next;
      adpc_reg <= adpc_next;
      sar_reg <= sar_next;
      ds_reg <= ds_next;
    end
  end

  // ==========================================================
  // function decode
  assign sel_if.dir = dir_reg;
  assign sel_if.segment_output = seg_reg;
  assign sel_if.analog = adpc_reg;
  assign sel_if.sar_sel = sar_reg;
  assign sel_if.ds_sel = ds_reg;
  assign sel_if.ds_variant = DS_VARIANT;

  pin_fn_decode u_decode (
    .sel(sel_if.dec)
  );

  // per-pin routing from decoded function
  // one code per pin keeps segment, sar, delta-sigma and drive mutually exclusive by construction
  logic [7:0] oe_n_w, seg_w, sar_w, ds_w, ana_w, bad_w;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_fn_t f;
      f = pin_fn_t'(sel_if.fn_flat[i*4 +: 4]);
      oe_n_w[i] = (f != FN_DIG_OUT);
      seg_w[i] = (f == FN_SEGMENT);
      sar_w[i] = (f == FN_ANALOG_SAR);
      ds_w[i] = (f == FN_ANALOG_DS);
      // prohibited settings keep the pin analog-off and driver-off
      ana_w[i] = (f == FN_ANALOG_IDLE) || (f == FN_ANALOG_SAR) || (f == FN_ANALOG_DS);
      bad_w[i] = (f == FN_PROHIBITED);
    end
  end

  // read mux; reserved bits read zero
  logic [31:0] rdata_w;
  always_comb begin
    rdata_w = 32'h0;
    if (hit_dir) rdata_w[7:0] = dir_reg;
    else if (hit_seg) rdata_w[7:0] = seg_reg;
    else if (hit_adpc) rdata_w[7:0] = adpc_reg;
    else if (hit_sar) rdata_w[3:0] = sar_reg;
    else if (hit_ds) rdata_w[3:0] = ds_reg;
    else if (hit_flo) rdata_w[15:0] = sel_if.fn_flat[15:0];
    else if (hit_fhi) rdata_w[15:0] = sel_if.fn_flat[31:16];
  end

  // outputs registered; routing lags a write by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_enable_n <= 8'hff;
      seg_enable <= 8'h00;
      sar_route <= 8'h00;
      ds_route <= 8'h00;
      analog_mode <= 8'h00;
      prohibited <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      out_enable_n <= oe_n_w;
      seg_enable <= seg_w;
      sar_route <= sar_w;
      ds_route <= ds_w;
      analog_mode <= ana_w;
      prohibited <= |bad_w;
      // setup phase: answer ready in the first access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata_w : 32'h0;
    end
  end

  // ==========================================================
  // checks
  dir_out_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !dir_reg[0] |=> !sar_route[0] && !ds_route[0] && !analog_mode[0])
    else $error("output-direction pin offered to converter");
  dir_oe_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (!adpc_reg[1] && !seg_reg[1]) |=> (out_enable_n[1] == $past(dir_reg[1])))
    else $error("digital pin buffer does not follow direction");
  dir_rst_a: assert property (@(posedge clk) disable iff (!arst_n)
    !rst_n_reg |-> dir_reg == 8'hff)
    else $error("direction not all ones in reset");
  byte_wr_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (wr && hit_dir) |=> dir_reg == $past(pwdata[7:0]))
    else $error("byte write of direction lost");
  bit_wr_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (wr && hit_bit) |=> dir_reg[$past(bit_idx)] == $past(bit_val))
    else $error("bit write of direction lost");
  sar_pick_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (sar_reg == 4'h8 && adpc_reg[0] && dir_reg[0] && !seg_reg[0] && !ds_w[0]
     && !(DS_VARIANT && ds_reg == 4'h8)) |=> sar_route[0])
    else $error("picked analog pin not routed to sar");
  both_pick_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (DS_VARIANT && sar_reg == ds_reg && sar_reg[3] && adpc_reg[sar_reg[2:0]]
     && dir_reg[sar_reg[2:0]]) |=> prohibited)
    else $error("double pick not flagged");
  idle_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (adpc_reg[2] && dir_reg[2] && !seg_reg[2] && !sar_reg[3] && !ds_reg[3])
    |=> analog_mode[2] && !sar_route[2] && !ds_route[2])
    else $error("unselected analog pin mis-routed");
  seg_win_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (!DS_VARIANT && seg_reg[3]) |=> seg_enable[3] && out_enable_n[3] && !analog_mode[3])
    else $error("segment choice not overriding");
  dig_cut_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (!adpc_reg[4] && !seg_reg[4]) |=> !analog_mode[4] && !sar_route[4])
    else $error("digital pin left on converter");
  ready_one_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    pready |=> !pready)
    else $error("bus ready held longer than one cycle");
  cov_bitw_c: cover property (@(posedge clk) disable iff (!rst_n_reg) wr && hit_bit);
  cov_sar_c: cover property (@(posedge clk) disable iff (!rst_n_reg) |sar_route);
  cov_ds_c: cover property (@(posedge clk) disable iff (!rst_n_reg) |ds_route);
  cov_seg_c: cover property (@(posedge clk) disable iff (!rst_n_reg) |seg_enable);
  cov_bad_c: cover property (@(posedge clk) disable iff (!rst_n_reg) prohibited);
endmodule

/* dv/converter_model.sv */
// converter-side model: watches the pin routing that the converters would sample
// assumes registered routing levels on clk, one converter channel at a time
`timescale 1ns/100ps
module converter_model (
  input wire logic clk,             // system clock
  input wire logic [7:0] sar_route, // pins offered to the sar converter
  input wire logic [7:0] ds_route,  // pins offered to the delta-sigma converter
  output logic clash                // more than one pin offered, or one pin to both
);
  // ==========================================================
  // sampling
  // a converter takes one channel; two offered pins would short the analog inputs
  always_ff @(posedge clk) begin
    clash <= ($countones(sar_route) > 1) || ($countones(ds_route) > 1) ||
             (|(sar_route & ds_route));
  end
endmodule

/* dv/port2_analog_pin_select_bench.sv */
// bench: both device variants side by side, driven over one apb master
// assumes one 200 MHz clock; a behavioural model predicts every pin function
`timescale 1ns/100ps
module port2_analog_pin_select_bench;
  import pin_select_pkg::*;
  logic clk, arst_n, psel, penable, pwrite;
  logic [1:0] err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd0, rd1;
  logic [31:0] prdata [2];
  logic [7:0] oen [2], sege [2], sarr [2], dsr [2], anm [2];
  logic pready [2], pslverr [2], prohib [2], clash [2];
  int n_errors = 0, tests_run = 0;
  int m_dir, m_seg, m_ana, m_sar, m_ds;
  // ==========================================================
  // designs and converter models, variant 0 and variant 1
  for (genvar g = 0; g < 2; g++) begin : gen_dut
    port2_analog_pin_select #(.DS_VARIANT(g == 1)) u_port2_analog_pin_select (.clk(clk),
      .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata[g]), .pready(pready[g]), .pslverr(pslverr[g]),
      .out_enable_n(oen[g]), .seg_enable(sege[g]), .sar_route(sarr[g]), .ds_route(dsr[g]),
      .analog_mode(anm[g]), .prohibited(prohib[g]));
    converter_model u_converter_model (.clk(clk), .sar_route(sarr[g]), .ds_route(dsr[g]),
      .clash(clash[g]));
  end
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, called just after a rising edge; answer taken at the pready edge,
  // then one idle cycle so the next call never re-raises psel in the same time step
  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready[0] !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd0 = prdata[0];
    rd1 = prdata[1];
    err = {pslverr[1], pslverr[0]};
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  // model: pin function code per variant, from the five settings
  function automatic int fn_code(int v, int i);
    bit s, d;
    s = m_sar[3] && m_sar[2:0] == i;
    d = v && m_ds[3] && m_ds[2:0] == i;
    if (!v && m_seg[i]) return 5;
    if (!m_ana[i]) return m_dir[i] ? 0 : 1;
    if (!m_dir[i] || (s && d)) return 6;
    return d ? 4 : (s ? 3 : 2);
  endfunction
  task automatic check_all();
    logic [31:0] fw [2];
    logic [7:0] e_oe, e_sg, e_sr, e_ds, e_an;
    bit e_pr;
    int c;
    // routing lags the last write by one edge, the converter model by one more
    @(posedge clk);
    for (int v = 0; v < 2; v++) begin
      @(negedge clk);
      e_pr = 0;
      fw[0] = '0;
      fw[1] = '0;
      for (int i = 0; i < 8; i++) begin
        c = fn_code(v, i);
        e_oe[i] = (c != 1); e_sg[i] = (c == 5); e_sr[i] = (c == 3); e_ds[i] = (c == 4);
        e_an[i] = (c >= 2 && c <= 4); e_pr |= (c == 6);
        fw[i / 4][4 * (i % 4) +: 4] = c[3:0];
      end
      chk("out_enable_n", oen[v], e_oe);
      chk("seg_enable", sege[v], e_sg);
      chk("sar_route", sarr[v], e_sr);
      chk("ds_route", dsr[v], e_ds);
      chk("analog_mode", anm[v], e_an);
      chk("prohibited", prohib[v], e_pr);
      chk("clash", clash[v], 0);
      // back on a rising edge before the bus request
      @(posedge clk);
      apb(0, FUNC_LO_OFF, 0);
      chk("fn_lo", v ? rd1 : rd0, fw[0]);
      apb(0, FUNC_HI_OFF, 0);
      chk("fn_hi", v ? rd1 : rd0, fw[1]);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  // ==========================================================
  // tests
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    void'($urandom(32'h5bcc));
    m_dir = 'hff; m_seg = 0; m_ana = 0; m_sar = 0; m_ds = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    apb(0, DIR_OFF, 0);
    chk("dir_reset", rd0, DIR_RESET);
    chk("dir_reset_v1", rd1, DIR_RESET);
    chk("pslverr_mapped", err, 2'b00);
    check_all();
    $display("test reset done");
    // single-bit writes clear the even bits, then set bit 2 again
    for (int i = 0; i < 8; i += 2) begin
      apb(1, DIR_BIT_OFF, 32'(i));
      m_dir[i] = 0;
    end
    apb(1, DIR_BIT_OFF, 32'h0a);
    m_dir[2] = 1;
    apb(0, DIR_OFF, 0);
    chk("dir_bits", rd0, m_dir);
    check_all();
    $display("test bit writes done");
    // unmapped write refused; status write ignored
    apb(1, 8'h20, 32'hff);
    chk("pslverr", err, 2'b11);
    apb(1, FUNC_LO_OFF, 32'hffff);
    check_all();
    $display("test refusals done");
    repeat (30) begin
      m_ana = $urandom_range(0, 255);
      m_seg = $urandom & $urandom & 'hff;
      m_sar = $urandom_range(0, 15);
      m_ds = $urandom_range(0, 15);
      // analog pins mostly set to input, sometimes not, to reach the prohibited case
      m_dir = ($urandom | ($urandom_range(0, 3) == 0 ? 0 : m_ana)) & 'hff;
      apb(1, DIR_OFF, m_dir);
      apb(1, SEG_OFF, m_seg);
      apb(1, ADPC_OFF, m_ana);
      apb(1, SAR_OFF, m_sar);
      apb(1, DS_OFF, m_ds);
      check_all();
    end
    $display("test random settings done");
    end_sim();
  end
endmodule
